// *** core/fpac_top.sv ***
// Purpose: protection and access control of an embedded flash interface
// Assumes: one clock, async active-high reset, Avalon-MM register slave
// Notes:   option values are captured on the first edge after reset release
//
// What this block does
// RQ1: code AA gives level 0, debug and boot source never block access
// RQ2: other codes, or erased options, give level 1
// RQ3: level 1 intrusion refuses access, reads bus-error
// RQ4: flash boot allows user access at levels 1-2
// RQ5: level 1 to 0 mass-erases flash and backup SRAM
// RQ6: raising protection never mass-erases
// RQ7: code CC gives level 2, debug locked off
// RQ8: level 2 can never be lowered
// RQ9: cleared sector bit blocks erase, program, mass erase
// RQ10: protected erase or program sets error flag
// RQ11: level 1 intrusion blocks program/erase despite sector bit
// RQ12: erase error cases set the error flag
// RQ13: program error cases set the error flag
// RQ14: otp has 16x32-byte blocks, never erasable
// RQ15: otp block programmable until its lock byte zero
// RQ16: software writes only 00 or FF to lock bytes
// RQ17: latency field gives zero to seven wait states
// RQ18: bits 8-10 enable prefetch, instruction, data cache
// RQ19: bit 11 flushes instruction cache while disabled only
// RQ20: bit 12 flushes data cache while disabled only
// RQ21: error flag is status bit 4, write one clears
// RQ22: read code sits in option bits 15:8
// RQ23: level and sector mask latched at reset release
`timescale 1ns/1ps
module fpac_top (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic [1:0]       o_avs_response,
	input  wire logic [7:0]  i_opt_rdp_code,
	input  wire logic [11:0] i_opt_wrp_bits,
	input  wire logic [15:0] i_otp_lock_state,
	input  wire logic        i_opt_upd_valid,
	input  wire logic [7:0]  i_opt_upd_rdp_code,
	input  wire logic [11:0] i_opt_upd_wrp_bits,
	input  wire logic        i_debug_attached,
	input  wire logic [1:0]  i_boot_src,
	input  wire logic        i_acc_valid,
	input  wire logic [1:0]  i_acc_kind,
	input  wire logic [2:0]  i_acc_area,
	input  wire logic [3:0]  i_acc_index,
	input  wire logic        i_acc_mass_erase_select,
	input  wire logic        i_acc_sector_erase_select,
	input  wire logic [7:0]  i_acc_wdata,
	output logic             o_acc_busy,
	output logic             o_acc_ack,
	output logic             o_acc_ok,
	output logic             o_acc_bus_err,
	output logic             o_mass_erase,
	output logic             o_opt_upd_reject,
	output logic             o_debug_disable,
	output logic             o_sysboot_block,
	output logic             o_prefetch_en,
	output logic             o_icache_en,
	output logic             o_dcache_en,
	output logic             o_icache_flush,
	output logic             o_dcache_flush,
	output logic [2:0]       o_latency
);
	// ==========================================================
	// helpers
	function automatic fpac_pkg::fpac_level_e lvl_of(input logic [7:0] code);
		if (code == fpac_pkg::RDP_CODE_L0)
			return fpac_pkg::LVL_0; // RQ1
		else if (code == fpac_pkg::RDP_CODE_L2)
			return fpac_pkg::LVL_2; // RQ7
		else
			return fpac_pkg::LVL_1; // RQ2
	endfunction : lvl_of

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : merge

	// ==========================================================
	// pin synchronisers
	logic [1:0] dbg_meta_r;
	logic [3:0] boot_meta_r;
	logic       dbg_r;
	logic [1:0] boot_r;
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dbg_meta_r  <= 2'h0;
			boot_meta_r <= 4'h0;
		end else begin
			dbg_meta_r  <= {dbg_meta_r[0], i_debug_attached};
			boot_meta_r <= {boot_meta_r[1:0], i_boot_src};
		end
	end
	assign dbg_r  = dbg_meta_r[1];
	assign boot_r = boot_meta_r[3:2];

	// ==========================================================
	// option capture and protection level
	fpac_pkg::fpac_level_e lvl_r;
	logic [7:0]  rdp_code_r;
	logic [11:0] wrp_r;
	logic        loaded_r;
	logic        l1_to_l0;
	assign l1_to_l0 = loaded_r && i_opt_upd_valid && lvl_r == fpac_pkg::LVL_1
		&& lvl_of(i_opt_upd_rdp_code) == fpac_pkg::LVL_0;

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lvl_r            <= fpac_pkg::LVL_1;
			rdp_code_r       <= 8'h00;
			wrp_r            <= 12'h000;
			loaded_r         <= 1'b0;
			o_mass_erase     <= 1'b0;
			o_opt_upd_reject <= 1'b0;
		end else begin
			o_mass_erase     <= 1'b0;
			o_opt_upd_reject <= 1'b0;
			if (!loaded_r) begin
				loaded_r   <= 1'b1; // RQ23
				rdp_code_r <= i_opt_rdp_code; // RQ22
				wrp_r      <= i_opt_wrp_bits;
				lvl_r      <= lvl_of(i_opt_rdp_code);
			end else if (i_opt_upd_valid) begin
				if (lvl_r == fpac_pkg::LVL_2) begin
					o_opt_upd_reject <= 1'b1; // RQ8
				end else begin
					rdp_code_r   <= i_opt_upd_rdp_code;
					wrp_r        <= i_opt_upd_wrp_bits;
					lvl_r        <= lvl_of(i_opt_upd_rdp_code);
					o_mass_erase <= l1_to_l0; // RQ5 RQ6
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_debug_disable <= 1'b0;
			o_sysboot_block <= 1'b0;
		end else begin
			o_debug_disable <= loaded_r && lvl_r == fpac_pkg::LVL_2; // RQ7
			o_sysboot_block <= loaded_r && lvl_r == fpac_pkg::LVL_2; // RQ7
		end
	end

	// ==========================================================
	// access decision
	fpac_pkg::fpac_kind_e kind;
	fpac_pkg::fpac_area_e area;
	logic intrusion;
	logic guarded;
	logic sec_prot;
	logic otp_locked;
	logic err_now;
	logic berr_now;
	logic take;
	logic [15:0] otp_lock_r;
	assign kind       = fpac_pkg::fpac_kind_e'(i_acc_kind);
	assign area       = fpac_pkg::fpac_area_e'(i_acc_area);
	assign intrusion  = lvl_r != fpac_pkg::LVL_0
		&& (dbg_r || boot_r != 2'(fpac_pkg::BOOT_FLASH)); // RQ3 RQ4 RQ11
	assign guarded    = area == fpac_pkg::AREA_MAIN || area == fpac_pkg::AREA_BKSRAM
		|| area == fpac_pkg::AREA_OTP_DATA || area == fpac_pkg::AREA_OTP_LOCK;
	assign sec_prot   = i_acc_index > fpac_pkg::LAST_SECTOR || !wrp_r[i_acc_index]; // RQ9
	assign otp_locked = otp_lock_r[i_acc_index]; // RQ15
	assign take       = i_acc_valid && !o_acc_busy && loaded_r;

	always_comb begin
		err_now  = 1'b0;
		berr_now = 1'b0;
		unique case (kind)
			fpac_pkg::KIND_READ: begin
				berr_now = guarded && intrusion; // RQ3
			end
			fpac_pkg::KIND_PROGRAM: begin
				unique case (area)
					fpac_pkg::AREA_MAIN:      err_now = sec_prot; // RQ13
					fpac_pkg::AREA_BKSRAM:    err_now = 1'b0;
					fpac_pkg::AREA_OTP_DATA:  err_now = otp_locked; // RQ13 RQ15
					fpac_pkg::AREA_OTP_LOCK:  err_now = 1'b0;
					default:                  err_now = 1'b1; // RQ10 RQ13
				endcase
				err_now = err_now || (guarded && intrusion); // RQ11 RQ13
			end
			fpac_pkg::KIND_ERASE: begin
				if (i_acc_mass_erase_select == i_acc_sector_erase_select)
					err_now = 1'b1; // RQ12
				else if (i_acc_sector_erase_select)
					err_now = sec_prot; // RQ9 RQ12
				else
					err_now = wrp_r != {fpac_pkg::NUM_SECTORS{1'b1}}; // RQ9 RQ12
				err_now = err_now || area != fpac_pkg::AREA_MAIN || intrusion; // RQ12 RQ14
			end
			default: begin
				err_now = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// access sequencing with wait states
	typedef enum logic {ST_IDLE, ST_WAIT} fpac_acc_st_e;
	fpac_acc_st_e st_r;
	logic pend_err_r;
	logic pend_berr_r;
	logic pend_lock_r;
	logic [3:0] pend_idx_r;
	logic wg_done;

	fpac_wait_gen u_wait (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (take),
		.i_latency (o_latency),
		.o_done    (wg_done)
	);

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_r          <= ST_IDLE;
			o_acc_busy    <= 1'b0;
			o_acc_ack     <= 1'b0;
			o_acc_ok      <= 1'b0;
			o_acc_bus_err <= 1'b0;
			pend_err_r    <= 1'b0;
			pend_berr_r   <= 1'b0;
			pend_lock_r   <= 1'b0;
			pend_idx_r    <= 4'h0;
		end else begin
			o_acc_ack     <= 1'b0;
			o_acc_ok      <= 1'b0;
			o_acc_bus_err <= 1'b0;
			unique case (st_r)
				ST_IDLE: begin
					if (take) begin
						st_r        <= ST_WAIT;
						o_acc_busy  <= 1'b1;
						pend_err_r  <= err_now;
						pend_berr_r <= berr_now;
						pend_idx_r  <= i_acc_index;
						pend_lock_r <= kind == fpac_pkg::KIND_PROGRAM && area == fpac_pkg::AREA_OTP_LOCK
							&& i_acc_wdata == fpac_pkg::OTP_LOCKED && !err_now;
					end
				end
				ST_WAIT: begin
					if (wg_done) begin
						st_r          <= ST_IDLE;
						o_acc_busy    <= 1'b0;
						o_acc_ack     <= 1'b1;
						o_acc_ok      <= !pend_err_r && !pend_berr_r;
						o_acc_bus_err <= pend_berr_r; // RQ3
					end
				end
			endcase
		end
	end

	// otp lock state, loaded once then tightened by lock-byte programs
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			otp_lock_r <= 16'h0000;
		end else if (!loaded_r) begin
			otp_lock_r <= i_otp_lock_state;
		end else if (st_r == ST_WAIT && wg_done && pend_lock_r) begin
			otp_lock_r[pend_idx_r] <= 1'b1; // RQ15 RQ16
		end
	end

	// ==========================================================
	// register slave
	logic        sel_acr;
	logic        sel_sr;
	logic        sel_opt;
	logic        req;
	logic        wr_go;
	logic [31:0] acr_new;
	logic        write_protect_error_flag_r;
	logic [31:0] acr_r;
	assign sel_acr = i_avs_address == fpac_pkg::OFF_ACCESS_CTRL;
	assign sel_sr  = i_avs_address == fpac_pkg::OFF_STATUS;
	assign sel_opt = i_avs_address == fpac_pkg::OFF_OPTION_CTRL;
	assign req     = i_avs_read || i_avs_write;
	assign wr_go   = i_avs_write && !o_avs_waitrequest;
	assign acr_new = merge(acr_r, i_avs_writedata, i_avs_byteenable);

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
			o_avs_response    <= fpac_pkg::RESP_OKAY;
		end else if (!o_avs_waitrequest) begin
			o_avs_waitrequest <= 1'b1;
		end else if (req) begin
			o_avs_waitrequest <= 1'b0;
			o_avs_response    <= (sel_acr || sel_sr || sel_opt) ? fpac_pkg::RESP_OKAY : fpac_pkg::RESP_DECERR;
			o_avs_readdata    <= 32'h0000_0000;
			if (i_avs_read && sel_acr)
				o_avs_readdata <= acr_r;
			else if (i_avs_read && sel_sr)
				o_avs_readdata <= 32'(write_protect_error_flag_r) << fpac_pkg::WRITE_PROTECT_ERROR_FLAG_BIT; // RQ21
			else if (i_avs_read && sel_opt)
				o_avs_readdata <= (32'(wrp_r) << fpac_pkg::WRP_LSB) | (32'(rdp_code_r) << fpac_pkg::RDP_LSB);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			acr_r <= fpac_pkg::ACCESS_CTRL_RST;
		end else if (wr_go && sel_acr) begin
			acr_r[fpac_pkg::LAT_LSB +: fpac_pkg::LAT_W] <= acr_new[fpac_pkg::LAT_LSB +: fpac_pkg::LAT_W]; // RQ17
			acr_r[fpac_pkg::PRFT_BIT] <= acr_new[fpac_pkg::PRFT_BIT]; // RQ18
			acr_r[fpac_pkg::INSTR_CACHE_ENABLE_BIT_BIT] <= acr_new[fpac_pkg::INSTR_CACHE_ENABLE_BIT_BIT]; // RQ18
			acr_r[fpac_pkg::DATA_CACHE_ENABLE_BIT_BIT] <= acr_new[fpac_pkg::DATA_CACHE_ENABLE_BIT_BIT]; // RQ18
			if (!acr_r[fpac_pkg::INSTR_CACHE_ENABLE_BIT_BIT])
				acr_r[fpac_pkg::ICFLUSH_BIT] <= acr_new[fpac_pkg::ICFLUSH_BIT]; // RQ19
			if (!acr_r[fpac_pkg::DATA_CACHE_ENABLE_BIT_BIT])
				acr_r[fpac_pkg::DCFLUSH_BIT] <= acr_new[fpac_pkg::DCFLUSH_BIT]; // RQ20
		end
	end

	// set wins over a same-cycle write-one clear
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			write_protect_error_flag_r <= fpac_pkg::STATUS_RST[fpac_pkg::WRITE_PROTECT_ERROR_FLAG_BIT];
		end else if (st_r == ST_WAIT && wg_done && pend_err_r) begin
			write_protect_error_flag_r <= 1'b1; // RQ10 RQ21
		end else if (wr_go && sel_sr && i_avs_byteenable[0] && i_avs_writedata[fpac_pkg::WRITE_PROTECT_ERROR_FLAG_BIT]) begin
			write_protect_error_flag_r <= 1'b0; // RQ21
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_latency      <= 3'h0;
			o_prefetch_en  <= 1'b0;
			o_icache_en    <= 1'b0;
			o_dcache_en    <= 1'b0;
			o_icache_flush <= 1'b0;
			o_dcache_flush <= 1'b0;
		end else begin
			o_latency      <= acr_r[fpac_pkg::LAT_LSB +: fpac_pkg::LAT_W]; // RQ17
			o_prefetch_en  <= acr_r[fpac_pkg::PRFT_BIT]; // RQ18
			o_icache_en    <= acr_r[fpac_pkg::INSTR_CACHE_ENABLE_BIT_BIT]; // RQ18
			o_dcache_en    <= acr_r[fpac_pkg::DATA_CACHE_ENABLE_BIT_BIT]; // RQ18
			o_icache_flush <= acr_r[fpac_pkg::ICFLUSH_BIT]; // RQ19
			o_dcache_flush <= acr_r[fpac_pkg::DCFLUSH_BIT]; // RQ20
		end
	end

	// ==========================================================
	// checks
	sequence s_take_read_intr;
		take && kind == fpac_pkg::KIND_READ && area == fpac_pkg::AREA_MAIN && intrusion;
	endsequence
	sequence s_ack_berr;
		o_acc_ack && o_acc_bus_err && !o_acc_ok;
	endsequence

	a_level_zero_code: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ1
		loaded_r |-> ((rdp_code_r == fpac_pkg::RDP_CODE_L0) == (lvl_r == fpac_pkg::LVL_0)))
		else $error("level 0 not tied to code AA");
	a_level_one_code: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ2
		(loaded_r && rdp_code_r != fpac_pkg::RDP_CODE_L0 && rdp_code_r != fpac_pkg::RDP_CODE_L2)
		|-> lvl_r == fpac_pkg::LVL_1)
		else $error("other code did not give level 1");
	a_intrusion_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ3
		s_take_read_intr |-> ##[2:10] s_ack_berr)
		else $error("intruding read not answered with bus error");
	a_erase_downgrade: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ5
		l1_to_l0 |=> o_mass_erase)
		else $error("level 1 to 0 without mass erase");
	a_no_erase_raise: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ6
		o_mass_erase |-> $past(lvl_r) == fpac_pkg::LVL_1 && lvl_r == fpac_pkg::LVL_0)
		else $error("mass erase outside downgrade");
	a_level_two_held: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ8
		(loaded_r && lvl_r == fpac_pkg::LVL_2) |=> lvl_r == fpac_pkg::LVL_2 && o_debug_disable)
		else $error("level 2 lowered");
	a_sector_blocked: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ9
		(take && kind == fpac_pkg::KIND_PROGRAM && area == fpac_pkg::AREA_MAIN && sec_prot)
		|-> ##[2:10] (o_acc_ack && !o_acc_ok) ##0 write_protect_error_flag_r)
		else $error("protected sector program not refused");
	a_err_flag_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ10
		(st_r == ST_WAIT && wg_done && pend_err_r) |=> write_protect_error_flag_r && o_acc_ack)
		else $error("error flag not set on refused access");
	a_icflush_guard: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ19
		acr_r[fpac_pkg::INSTR_CACHE_ENABLE_BIT_BIT] |=> $stable(acr_r[fpac_pkg::ICFLUSH_BIT]))
		else $error("instruction cache flush changed while enabled");
	a_dcflush_guard: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ20
		acr_r[fpac_pkg::DATA_CACHE_ENABLE_BIT_BIT] |=> $stable(acr_r[fpac_pkg::DCFLUSH_BIT]))
		else $error("data cache flush changed while enabled");
endmodule : fpac_top

// *** core/fpac_pkg.sv ***
// Purpose: shared constants and types of the flash protection and access control block
// Assumes: Avalon-MM byte addresses, 32-bit data
// Notes:   all offsets, field positions, reset values and codes live here
package fpac_pkg;
	// ==========================================================
	// register map
	localparam logic [4:0] OFF_ACCESS_CTRL = 5'h00;
	localparam logic [4:0] OFF_STATUS      = 5'h0C;
	localparam logic [4:0] OFF_OPTION_CTRL = 5'h14;
	localparam logic [31:0] ACCESS_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] STATUS_RST      = 32'h0000_0000;
	// ==========================================================
	// access control fields
	localparam int LAT_LSB     = 0;
	localparam int LAT_W       = 3;
	localparam int PRFT_BIT    = 8;
	localparam int INSTR_CACHE_ENABLE_BIT_BIT    = 9;
	localparam int DATA_CACHE_ENABLE_BIT_BIT    = 10;
	localparam int ICFLUSH_BIT = 11;
	localparam int DCFLUSH_BIT = 12;
	// status and option control fields
	localparam int WRITE_PROTECT_ERROR_FLAG_BIT  = 4;
	localparam int RDP_LSB     = 8;
	localparam int WRP_LSB     = 16;
	// ==========================================================
	// protection codes and geometry
	localparam logic [7:0] RDP_CODE_L0  = 8'hAA;
	localparam logic [7:0] RDP_CODE_L2  = 8'hCC;
	localparam logic [7:0] OTP_LOCKED   = 8'h00;
	localparam int         NUM_SECTORS  = 12;
	localparam logic [3:0] LAST_SECTOR  = 4'hB;
	localparam int         OTP_BLOCKS   = 16;
	localparam int         OTP_BLK_BYTES  = 32;
	localparam int         OTP_LOCK_BYTES = 16;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_DECERR  = 2'h3;
	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {LVL_0, LVL_1, LVL_2} fpac_level_e;
	typedef enum logic [1:0] {KIND_READ, KIND_PROGRAM, KIND_ERASE} fpac_kind_e;
	typedef enum logic [1:0] {BOOT_FLASH, BOOT_SYSMEM, BOOT_RAM} fpac_boot_e;
	typedef enum logic [2:0] {
		AREA_MAIN, AREA_BKSRAM, AREA_OTP_DATA, AREA_OTP_LOCK,
		AREA_SYSMEM, AREA_USER_RSVD, AREA_USER_CFG, AREA_ICP
	} fpac_area_e;
endpackage : fpac_pkg

// *** core/fpac_wait_gen.sv ***
// Purpose: flash wait-state timer, one done pulse per started access
// Assumes: start only while idle
// Notes:   done rises latency+1 edges after the start edge
`timescale 1ns/1ps
module fpac_wait_gen (
	input  wire logic       i_ref_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_start,
	input  wire logic [2:0] i_latency,
	output logic            o_done
);
	logic [2:0] cnt_r;
	logic       busy_r;

	// ==========================================================
	// countdown
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r  <= 3'h0;
			busy_r <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start && !busy_r) begin
				cnt_r  <= i_latency; // RQ17
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (cnt_r == 3'h0) begin
					busy_r <= 1'b0;
					o_done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 3'h1; // RQ17
				end
			end
		end
	end

	a_wait_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ17
		(i_start && !busy_r && i_latency == 3'h0) |=> ##1 o_done)
		else $error("zero latency access not done after one edge");
	a_wait_seven: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // RQ17
		(i_start && !busy_r && i_latency == 3'h7) |=> !o_done [*8] ##1 o_done)
		else $error("seven wait states not honoured");
endmodule : fpac_wait_gen

// *** verification/fpac_cpu_model.sv ***
// Purpose: cpu side model that issues requests on the flash access port
// Assumes: one request at a time, options already captured
// Notes:   expected ok and bus error bits are queued for the bench monitor
`timescale 1ns/1ps
module fpac_cpu_model (
	input  wire logic  i_ref_clk,
	input  wire logic  i_acc_ack,
	output logic       o_acc_valid,
	output logic [1:0] o_acc_kind,
	output logic [2:0] o_acc_area,
	output logic [3:0] o_acc_index,
	output logic       o_acc_mass_erase_select,
	output logic       o_acc_sector_erase_select,
	output logic [7:0] o_acc_wdata
);
	logic [1:0] exp_q[$];
	initial begin
		{o_acc_valid, o_acc_kind, o_acc_area, o_acc_index} = '0;
		{o_acc_mass_erase_select, o_acc_sector_erase_select, o_acc_wdata} = '0;
	end
	// ==========================================================
	// one request, then count falling edges up to the answer
	task automatic access(input logic [1:0] k, input logic [2:0] a, input logic [3:0] i,
		input logic [1:0] s, input logic [7:0] wd, input logic [1:0] e, output int lat);
		lat = -1;
		@(posedge i_ref_clk);
		o_acc_valid <= 1'b1;
		o_acc_kind <= k;
		o_acc_area <= a;
		o_acc_index <= i;
		{o_acc_mass_erase_select, o_acc_sector_erase_select} <= s;
		o_acc_wdata <= (a == 3'h3 && wd != 8'h00) ? 8'hFF : wd;
		exp_q.push_back(e);
		@(posedge i_ref_clk);
		o_acc_valid <= 1'b0;
		o_acc_wdata <= ~o_acc_wdata;
		do begin
			@(negedge i_ref_clk);
			lat++;
		end while (i_acc_ack !== 1'b1 && lat < 20);
	endtask : access
endmodule : fpac_cpu_model

// *** verification/fpac_top_tb_top.sv ***
// Purpose: self-checking bench of the flash protection and access control block
// Assumes: 10 MHz clock, Avalon master tasks, cpu model on the access port
// Notes:   results are queued by the drivers and compared by a monitor
`timescale 1ns/1ps
module fpac_top_tb_top;
	logic i_ref_clk = 0, i_sys_rst = 1, i_avs_read = 0, i_avs_write = 0, i_opt_upd_valid = 0;
	logic i_debug_attached = 0, wreq_s = 1;
	logic [4:0] i_avs_address = '0;
	logic [31:0] i_avs_writedata = '0, rnd = 32'd68416;
	logic [3:0] i_avs_byteenable = 4'hF;
	logic [7:0] i_opt_rdp_code = 8'hFF, i_opt_upd_rdp_code = '0;
	logic [11:0] i_opt_wrp_bits = 12'hFFF, i_opt_upd_wrp_bits = 12'hFFF;
	logic [15:0] i_otp_lock_state = '0;
	logic [1:0] i_boot_src = '0, i_acc_kind;
	logic i_acc_valid, i_acc_mass_erase_select, i_acc_sector_erase_select;
	logic [2:0] i_acc_area, o_latency;
	logic [3:0] i_acc_index;
	logic [7:0] i_acc_wdata;
	logic [31:0] o_avs_readdata;
	logic [1:0] o_avs_response, e2;
	logic o_avs_waitrequest, o_acc_busy, o_acc_ack, o_acc_ok, o_acc_bus_err, o_mass_erase;
	logic o_opt_upd_reject, o_debug_disable, o_sysboot_block, o_prefetch_en, o_icache_en;
	logic o_dcache_en, o_icache_flush, o_dcache_flush;
	logic [65:0] rd_q[$], er;
	int bad_count = 0, checked = 0, cur_lat = 0;
	wire [7:0] acr_outs = {o_prefetch_en, o_icache_en, o_dcache_en, o_icache_flush, o_dcache_flush, o_latency};
	localparam logic [4:0] ACR = fpac_pkg::OFF_ACCESS_CTRL, SR = fpac_pkg::OFF_STATUS;
	localparam logic [2:0] MN = fpac_pkg::AREA_MAIN;
	localparam logic [1:0] RD = fpac_pkg::KIND_READ, PG = fpac_pkg::KIND_PROGRAM, ER = fpac_pkg::KIND_ERASE;
	localparam logic [1:0] OK = fpac_pkg::RESP_OKAY;
	fpac_top u_dut (.i_ref_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
		.i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_avs_response, .i_opt_rdp_code,
		.i_opt_wrp_bits, .i_otp_lock_state, .i_opt_upd_valid, .i_opt_upd_rdp_code, .i_opt_upd_wrp_bits,
		.i_debug_attached, .i_boot_src, .i_acc_valid, .i_acc_kind, .i_acc_area, .i_acc_index,
		.i_acc_mass_erase_select, .i_acc_sector_erase_select, .i_acc_wdata, .o_acc_busy, .o_acc_ack,
		.o_acc_ok, .o_acc_bus_err, .o_mass_erase, .o_opt_upd_reject, .o_debug_disable, .o_sysboot_block,
		.o_prefetch_en, .o_icache_en, .o_dcache_en, .o_icache_flush, .o_dcache_flush, .o_latency);
	fpac_cpu_model u_cpu (.i_ref_clk(i_ref_clk), .i_acc_ack(o_acc_ack), .o_acc_valid(i_acc_valid),
		.o_acc_kind(i_acc_kind), .o_acc_area(i_acc_area), .o_acc_index(i_acc_index),
		.o_acc_mass_erase_select(i_acc_mass_erase_select),
		.o_acc_sector_erase_select(i_acc_sector_erase_select), .o_acc_wdata(i_acc_wdata));
	initial begin
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic close_out();
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic do_reset(input logic [7:0] c, input logic [11:0] w, input logic [15:0] l);
		@(posedge i_ref_clk);
		i_sys_rst <= 1'b1;
		i_opt_rdp_code <= c;
		i_opt_wrp_bits <= w;
		i_otp_lock_state <= l;
		repeat (16) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		cur_lat = 0;
		repeat (4) @(posedge i_ref_clk);
	endtask : do_reset
	task automatic av_req(input logic [4:0] a, input logic wr, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		i_avs_address <= a;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		i_avs_writedata <= d;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (wreq_s !== 1'b0 && n < 50);
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		if (n >= 50) check("avs_timeout", 0, 1);
	endtask : av_req
	task automatic av_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
		rd_q.push_back({r, m, e});
		av_req(a, 1'b0, 32'h0);
	endtask : av_rd
	task automatic acc(input logic [1:0] k, input logic [2:0] a, input logic [3:0] i, input logic [1:0] s,
		input logic [7:0] wd, input logic [1:0] e);
		int lat;
		u_cpu.access(k, a, i, s, wd, e, lat);
		check("ack_latency", cur_lat + 2, lat);
		rnd = lfsr(rnd);
	endtask : acc
	task automatic opt_upd(input logic [7:0] c, input logic m, input logic r);
		@(posedge i_ref_clk);
		i_opt_upd_valid <= 1'b1;
		i_opt_upd_rdp_code <= c;
		@(posedge i_ref_clk);
		i_opt_upd_valid <= 1'b0;
		@(negedge i_ref_clk);
		check("mass_erase", m, o_mass_erase);
		check("upd_reject", r, o_opt_upd_reject);
	endtask : opt_upd
	task automatic pins(input logic d, input logic [1:0] b);
		@(posedge i_ref_clk);
		i_debug_attached <= d;
		i_boot_src <= b;
		repeat (4) @(posedge i_ref_clk);
	endtask : pins
	// ==========================================================
	// monitor: oldest note against each result
	always @(negedge i_ref_clk) begin
		wreq_s <= o_avs_waitrequest;
		if (o_acc_ack === 1'b1) begin
			e2 = (u_cpu.exp_q.size() > 0) ? u_cpu.exp_q.pop_front() : 2'bxx;
			check("acc_ok_buserr", e2, {o_acc_ok, o_acc_bus_err});
			check("acc_busy", 32'h0, o_acc_busy);
		end
		if (i_avs_read && o_avs_waitrequest === 1'b0) begin
			er = (rd_q.size() > 0) ? rd_q.pop_front() : 'x;
			check("readdata", er[31:0], o_avs_readdata & er[63:32]);
			check("response", er[65:64], o_avs_response);
		end
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		bad_count++;
		close_out();
	end
	// ==========================================================
	// scenarios
	initial begin
		do_reset(8'hFF, 12'hFFF, 16'h0000);
		av_rd(ACR, fpac_pkg::ACCESS_CTRL_RST, '1, OK);
		av_rd(SR, fpac_pkg::STATUS_RST, '1, OK);
		av_rd(fpac_pkg::OFF_OPTION_CTRL, 32'h0FFFFF00, 32'h0FFFFF00, OK);
		av_rd(5'h04, 32'h0, '1, fpac_pkg::RESP_DECERR);
		av_req(ACR, 1'b1, 32'h0600);
		av_req(ACR, 1'b1, 32'h1E00);
		av_rd(ACR, 32'h0600, '1, OK);
		check("acr_outs", 8'h60, acr_outs);
		cur_lat = rnd[10:8];
		av_req(ACR, 1'b1, 32'h0100 | cur_lat);
		av_req(ACR, 1'b1, 32'h1900 | cur_lat);
		av_rd(ACR, 32'h1900 | cur_lat, '1, OK);
		check("acr_outs", {5'h13, cur_lat[2:0]}, acr_outs);
		acc(RD, MN, 4'h0, 2'b00, rnd[7:0], 2'b10);
		acc(PG, fpac_pkg::AREA_BKSRAM, 4'h0, 2'b00, rnd[7:0], 2'b10);
		pins(1'b1, fpac_pkg::BOOT_FLASH);
		acc(RD, MN, 4'h1, 2'b00, rnd[7:0], 2'b01);
		acc(RD, fpac_pkg::AREA_OTP_DATA, 4'h2, 2'b00, rnd[7:0], 2'b01);
		acc(PG, MN, 4'h2, 2'b00, rnd[7:0], 2'b00);
		av_rd(SR, 32'h10, 32'h10, OK);
		av_req(SR, 1'b1, 32'h10);
		av_rd(SR, 32'h0, 32'h10, OK);
		pins(1'b0, fpac_pkg::BOOT_RAM);
		acc(ER, MN, 4'h1, 2'b01, rnd[7:0], 2'b00);
		pins(1'b0, fpac_pkg::BOOT_SYSMEM);
		acc(RD, fpac_pkg::AREA_BKSRAM, 4'h0, 2'b00, rnd[7:0], 2'b01);
		opt_upd(fpac_pkg::RDP_CODE_L0, 1'b1, 1'b0);
		pins(1'b1, fpac_pkg::BOOT_RAM);
		acc(RD, MN, 4'h3, 2'b00, rnd[7:0], 2'b10);
		opt_upd(fpac_pkg::RDP_CODE_L2, 1'b0, 1'b0);
		acc(RD, MN, 4'h3, 2'b00, rnd[7:0], 2'b01);
		check("lvl2_locks", 2'b11, {o_debug_disable, o_sysboot_block});
		opt_upd(fpac_pkg::RDP_CODE_L0, 1'b0, 1'b1);
		check("lvl2_locks", 2'b11, {o_debug_disable, o_sysboot_block});
		do_reset(fpac_pkg::RDP_CODE_L0, 12'hFF7, 16'h0002);
		av_req(ACR, 1'b1, 32'h7);
		cur_lat = 7;
		acc(PG, MN, 4'h3, 2'b00, rnd[7:0], 2'b00);
		acc(PG, MN, 4'hB, 2'b00, rnd[7:0], 2'b10);
		acc(ER, MN, 4'h0, 2'b10, rnd[7:0], 2'b00);
		acc(ER, MN, 4'h0, 2'b11, rnd[7:0], 2'b00);
		acc(ER, MN, 4'hC, 2'b01, rnd[7:0], 2'b00);
		acc(ER, MN, 4'hB, 2'b01, rnd[7:0], 2'b10);
		acc(ER, fpac_pkg::AREA_OTP_DATA, 4'h0, 2'b01, rnd[7:0], 2'b00);
		acc(ER, fpac_pkg::AREA_OTP_LOCK, 4'h0, 2'b01, rnd[7:0], 2'b00);
		for (int a = 4; a < 8; a++) acc(PG, a[2:0], 4'h0, 2'b00, rnd[7:0], 2'b00);
		acc(PG, fpac_pkg::AREA_OTP_DATA, 4'h1, 2'b00, rnd[7:0], 2'b00);
		acc(PG, fpac_pkg::AREA_OTP_DATA, 4'hF, 2'b00, rnd[7:0], 2'b10);
		acc(PG, fpac_pkg::AREA_OTP_LOCK, 4'hF, 2'b00, 8'h00, 2'b10);
		acc(PG, fpac_pkg::AREA_OTP_DATA, 4'hF, 2'b00, rnd[7:0], 2'b00);
		opt_upd(8'h55, 1'b0, 1'b0);
		pins(1'b1, fpac_pkg::BOOT_FLASH);
		acc(RD, MN, 4'h0, 2'b00, rnd[7:0], 2'b01);
		close_out();
	end
endmodule : fpac_top_tb_top
